// ### watchdog_timer_bench.sv
// Self-checking bench for the watchdog timer
module watchdog_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 0, rst_b_i = 0, por_b_i = 0, pmm_en_i = 0, ctl_wr_i = 0;
   logic restart_i = 0, warn_clr_i = 0, rstf_clr_i = 0, irq, req, rstf;
   logic [1:0] clk_div_sel_i = 2'h0;
   logic [7:0] ctl_wdata_i = 8'h00, ctl;
   logic [15:0] vec;
   int mismatches = 0, n_checks = 0;
   wdt_watchdog_timer dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i),
      .clk_div_sel_i(clk_div_sel_i), .pmm_en_i(pmm_en_i), .ctl_wr_i(ctl_wr_i),
      .ctl_wdata_i(ctl_wdata_i), .restart_i(restart_i), .warn_clr_i(warn_clr_i),
      .rstf_clr_i(rstf_clr_i), .watchdog_control_reg_o(ctl), .wdt_irq_o(irq),
      .sys_rst_req_o(req), .rst_vector_o(vec), .watchdog_reset_flag_o(rstf));
   initial forever #4 mclk_i = ~mclk_i;
   task chk(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (exp !== got) begin
         mismatches++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask
   task finish_test;
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge mclk_i) s = 1;
      @(negedge mclk_i) s = 0;
   endtask
   // Program control, restart, then time warning and reset request
   task t_timeout(logic [7:0] wd, int pre, int gap);
      int n;
      ctl_wdata_i = wd;
      pulse(ctl_wr_i);
      chk("ctl", {2'h0, wd[5], 2'h0, wd[2:0]}, ctl);
      pulse(restart_i);
      n = 1;
      while (!irq && n < 40000) @(negedge mclk_i) n++;
      chk("warn time", 1, n >= pre - 4 && n <= pre + 4);
      n = 0;
      while (!req && n < 40000) @(negedge mclk_i) n++;
      chk("warn gap", gap, n);
      chk("flag", 1, rstf);
      chk("vector", 16'h8000, vec);
      pulse(warn_clr_i);
      pulse(rstf_clr_i);
      chk("cleared", 2'h0, {irq, rstf});
   endtask
   // Restarts inside the shortest interval, by strobe and by write, keep warning and reset away
   task t_restart;
      ctl_wdata_i = 8'h24;
      pulse(ctl_wr_i);
      pulse(restart_i);
      repeat (3) begin
         repeat (3000) @(negedge mclk_i);
         chk("early", 2'h0, {irq, req});
         pulse(restart_i);
      end
      repeat (3000) @(negedge mclk_i);
      ctl_wdata_i = 8'h64;
      pulse(ctl_wr_i);
      repeat (3000) @(negedge mclk_i);
      chk("write restart", 2'h0, {irq, req});
   endtask
   // Slower system clocks, or a disabled watchdog, must stay quiet past the undivided time
   task t_quiet(logic [7:0] wd, logic [1:0] div, logic pmm);
      clk_div_sel_i = div;
      pmm_en_i = pmm;
      ctl_wdata_i = wd;
      pulse(ctl_wr_i);
      pulse(restart_i);
      repeat (4200) @(negedge mclk_i);
      chk("quiet", 2'h0, {irq, req});
   endtask
   initial begin
      repeat (10) @(negedge mclk_i);
      rst_b_i = 1;
      por_b_i = 1;
      chk("reset ctl", 8'h20, ctl);
      ctl_wdata_i = 8'hFF;
      pulse(ctl_wr_i);
      chk("reserved", 8'h27, ctl & 8'hE7);
      t_restart;
      t_timeout(8'h24, 3584, 512);
      clk_div_sel_i = 2'h1;
      t_timeout(8'h24, 7168, 1024);
      clk_div_sel_i = 2'h0;
      t_timeout(8'h25, 32256, 512);
      t_quiet(8'h24, 2'h2, 1'b0);
      t_quiet(8'h24, 2'h3, 1'b0);
      t_quiet(8'h24, 2'h0, 1'b1);
      t_quiet(8'h04, 2'h0, 1'b0);
      finish_test;
   end
   initial begin
      #760000;
      mismatches++;
      finish_test;
   end
endmodule // watchdog_timer_bench

// ### wdt_clk_div.v
// System clock enable divider: one pulse every 1, 2, 4, 8 or 256 oscillator cycles
module wdt_clk_div (
   input wire mclk_i,
   input wire rst_b_i,
   input wire [1:0] div_sel_i,
   input wire pmm_i,
   output reg sys_en_o
);
   reg [7:0] div_cnt_q;
   reg [7:0] div_max;

   always @* begin
      case (div_sel_i)
         2'h0: div_max = 8'h00;
         2'h1: div_max = 8'h01;
         2'h2: div_max = 8'h03;
         default: div_max = 8'h07;
      endcase
      if (pmm_i) begin
         div_max = 8'hFF;
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         div_cnt_q <= 8'h00;
         sys_en_o <= 1'b0;
      end else if (div_cnt_q >= div_max) begin
         div_cnt_q <= 8'h00;
         sys_en_o <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 8'h01;
         sys_en_o <= 1'b0;
      end
   end
endmodule // wdt_clk_div

// ### wdt_map.vh
// Constants for the watchdog timer: interval codes, counts, reset vector and control bits
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------------------------------
// Timing counts in system clocks
// ----------------------------------------------------------------
`define WDT_WARN_CLKS 22'h000200
`define WDT_SEL_W 2
`define WDT_SEL0_LOG2 5'h0C
`define WDT_SEL1_LOG2 5'h0F
`define WDT_SEL2_LOG2 5'h12
`define WDT_SEL3_LOG2 5'h15
`define WDT_CNT_W 22

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define WDT_CR_SEL_LO 0
`define WDT_CR_SEL_HI 1
`define WDT_CR_IE 2
`define WDT_CR_WARN 3
`define WDT_CR_RSTF 4
`define WDT_CR_EN 5
`define WDT_CR_RESTART 6
`define WDT_CR_W 8

// ----------------------------------------------------------------
// Reset values and vector
// ----------------------------------------------------------------
`define WDT_SEL_RST 2'h0
`define WDT_IE_RST 1'b0
`define WDT_EN_RST 1'b1
`define WDT_RSTF_RST 1'b0
`define WDT_RST_VECTOR 16'h8000
`define WDT_RST_PULSE_CLKS 4'h4

`endif

// ### wdt_watchdog_timer.v
// Watchdog timer: free-running counter, early warning interrupt and system reset request
`include "wdt_map.vh"

// Contract
// (RULE1) Counter free-runs on system clocks; a restart returns it to zero.
// (RULE2) Reaching the selected timeout without restart forces a full system reset.
// (RULE3) Enabled interrupt rises exactly 512 system clocks before the reset.
// (RULE4) Four timeouts selectable, 2^12 up to 2^21 system clocks.
// (RULE5) Counting uses system clock enables, so timeout scales with divide mode.
// (RULE6) Interval, interrupt enable, restart and status sit in one control register.
// (RULE7) A watchdog reset sets a readable reset flag in the control register.
// (RULE8) After a watchdog reset, execution begins at address 8000h.
// (RULE9) Restart clears the counter and cancels pending warning timing.
module wdt_watchdog_timer #(
   parameter CNT_W = `WDT_CNT_W
) (
   input wire mclk_i,
   input wire rst_b_i,
   input wire por_b_i,
   input wire [1:0] clk_div_sel_i,
   input wire pmm_en_i,
   input wire ctl_wr_i,
   input wire [`WDT_CR_W-1:0] ctl_wdata_i,
   input wire restart_i,
   input wire warn_clr_i,
   input wire rstf_clr_i,
   output wire [`WDT_CR_W-1:0] watchdog_control_reg_o,
   output reg wdt_irq_o,
   output reg sys_rst_req_o,
   output reg [15:0] rst_vector_o,
   output wire watchdog_reset_flag_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function [CNT_W-1:0] timeout_of;
      input [1:0] sel;
      reg [4:0] lg;
      begin
         case (sel)
            2'h0: lg = `WDT_SEL0_LOG2;
            2'h1: lg = `WDT_SEL1_LOG2;
            2'h2: lg = `WDT_SEL2_LOG2;
            default: lg = `WDT_SEL3_LOG2;
         endcase
         timeout_of = {{(CNT_W-1){1'b0}}, 1'b1} << lg; // [RULE4]
      end
   endfunction

   // ----------------------------------------------------------------
   // System clock enable
   // ----------------------------------------------------------------
   // The counter only moves on enables, so every divide mode except divide by 1 stretches the timeout.
   wire sys_en;

   wdt_clk_div u_div (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .div_sel_i(clk_div_sel_i),
      .pmm_i(pmm_en_i),
      .sys_en_o(sys_en)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg [1:0] sel_q;
   reg [1:0] sel_d;
   reg ie_q;
   reg ie_d;
   reg en_q;
   reg en_d;
   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] cnt_d;
   reg warn_q;
   reg warn_d;
   reg irq_d;
   reg [3:0] pulse_q;
   reg [3:0] pulse_d;
   reg req_d;
   // The flag sits in the power-on domain so that it survives the reset it causes.
   reg rstf_q;
   reg rstf_d;

   // ----------------------------------------------------------------
   // Compare points and restart
   // ----------------------------------------------------------------
   wire [CNT_W-1:0] tmo = timeout_of(sel_q);
   wire [CNT_W-1:0] warn_at = tmo - `WDT_WARN_CLKS;
   wire hit_warn = en_q && sys_en && (cnt_q == warn_at - {{(CNT_W-1){1'b0}}, 1'b1});
   wire hit_tmo = en_q && sys_en && (cnt_q == tmo - {{(CNT_W-1){1'b0}}, 1'b1});
   // A control write with the restart bit acts like the restart strobe
   wire restart = restart_i || (ctl_wr_i && ctl_wdata_i[`WDT_CR_RESTART]); // [RULE6]
   // Restart beats a warning or timeout that falls in the same cycle
   wire warn_set = hit_warn && !restart;
   wire tmo_set = hit_tmo && !restart;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always @* begin
      sel_d = sel_q;
      ie_d = ie_q;
      en_d = en_q;
      if (ctl_wr_i) begin
         sel_d = ctl_wdata_i[`WDT_CR_SEL_HI:`WDT_CR_SEL_LO]; // [RULE6]
         ie_d = ctl_wdata_i[`WDT_CR_IE];
         en_d = ctl_wdata_i[`WDT_CR_EN];
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sel_q <= `WDT_SEL_RST;
         ie_q <= `WDT_IE_RST;
         en_q <= `WDT_EN_RST;
      end else begin
         sel_q <= sel_d;
         ie_q <= ie_d;
         en_q <= en_d;
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // It keeps running past the timeout; the requested system reset clears it.
   always @* begin
      cnt_d = cnt_q;
      if (restart || !en_q) begin
         cnt_d = {CNT_W{1'b0}}; // [RULE1] [RULE9]
      end else if (sys_en) begin
         cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE5]
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         cnt_q <= {CNT_W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Warning flag and interrupt
   // ----------------------------------------------------------------
   always @* begin
      warn_d = warn_q;
      if (warn_set) begin
         warn_d = 1'b1; // [RULE3]
      end else if (warn_clr_i || restart) begin
         warn_d = 1'b0; // [RULE9]
      end
      irq_d = ie_q && warn_d; // [RULE3]
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         warn_q <= 1'b0;
         wdt_irq_o <= 1'b0;
      end else begin
         warn_q <= warn_d;
         wdt_irq_o <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // System reset request
   // ----------------------------------------------------------------
   // A short pulse is enough: the reset it causes clears this block too.
   always @* begin
      pulse_d = pulse_q;
      req_d = 1'b0;
      if (tmo_set) begin
         pulse_d = `WDT_RST_PULSE_CLKS; // [RULE2] [RULE4]
         req_d = 1'b1;
      end else if (pulse_q != 4'h0) begin
         pulse_d = pulse_q - 4'h1;
         req_d = (pulse_q != 4'h1);
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         pulse_q <= 4'h0;
         sys_rst_req_o <= 1'b0;
      end else begin
         pulse_q <= pulse_d;
         sys_rst_req_o <= req_d;
      end
   end

   // ----------------------------------------------------------------
   // Reset flag and vector
   // ----------------------------------------------------------------
   always @* begin
      rstf_d = rstf_q;
      if (tmo_set && rst_b_i) begin
         rstf_d = 1'b1; // [RULE7]
      end else if (rstf_clr_i) begin
         rstf_d = 1'b0;
      end
   end

   always @(posedge mclk_i) begin
      if (!por_b_i) begin
         rstf_q <= `WDT_RSTF_RST;
         rst_vector_o <= `WDT_RST_VECTOR;
      end else begin
         rstf_q <= rstf_d;
         rst_vector_o <= `WDT_RST_VECTOR; // [RULE8]
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign watchdog_reset_flag_o = rstf_q;
   assign watchdog_control_reg_o = {2'h0, en_q, rstf_q, warn_q, ie_q, sel_q}; // [RULE6]

endmodule // wdt_watchdog_timer

// ### wdt_watchdog_timer_asserts.sv
// Checker for the watchdog timer: warning, reset request and flag timing
module wdt_watchdog_timer_chk (
   input logic mclk_i,
   input logic rst_b_i,
   input logic [1:0] clk_div_sel_i,
   input logic pmm_en_i,
   input logic ctl_wr_i,
   input logic [7:0] ctl_wdata_i,
   input logic restart_i,
   input logic [7:0] watchdog_control_reg_o,
   input logic wdt_irq_o,
   input logic sys_rst_req_o,
   input logic [15:0] rst_vector_o,
   input logic watchdog_reset_flag_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // Only the undivided clock gives a fixed 512 cycle gap
   AST_WARN_GAP: assert property ($rose(sys_rst_req_o) && clk_div_sel_i == 2'h0 && !pmm_en_i
      |-> $past(watchdog_control_reg_o[3], 512) && !$past(watchdog_control_reg_o[3], 513))
      else $error("warning not 512 clocks before reset");
   AST_REQ_PULSE: assert property ($rose(sys_rst_req_o) |-> sys_rst_req_o[*4] ##1 !sys_rst_req_o)
      else $error("reset request not four cycles");
   AST_RSTF_SET: assert property ($rose(sys_rst_req_o) |-> watchdog_reset_flag_o)
      else $error("reset flag not set");
   AST_VECTOR: assert property (rst_vector_o == 16'h8000)
      else $error("reset vector wrong");
   AST_RESTART: assert property (restart_i |=> !wdt_irq_o[*8])
      else $error("irq after restart");
   AST_IRQ_WARN: assert property (wdt_irq_o |-> watchdog_control_reg_o[3])
      else $error("irq without warning flag");
   AST_FLAG_MIRROR: assert property (watchdog_reset_flag_o == watchdog_control_reg_o[4])
      else $error("flag output differs from register");
   AST_WRITE: assert property (ctl_wr_i |=> watchdog_control_reg_o[2:0] == $past(ctl_wdata_i[2:0]))
      else $error("control write lost");
   C_IRQ: cover property ($rose(wdt_irq_o));
   C_REQ: cover property ($rose(sys_rst_req_o));
   C_RESTART: cover property (restart_i);
endmodule // wdt_watchdog_timer_chk
bind wdt_watchdog_timer wdt_watchdog_timer_chk u_chk (.*);
